//--- rtl/nvm_control.sv
// APB register file and control logic for program Flash, data EEPROM and config space
// Behaviour
// [RL1] Low address byte, read/write, resets zero
// [RL2] High address seven bits, top reads one
// [RL3] Flash select set: Flash, clear: EEPROM
// [RL4] Config select redirects to config and IDs
// [RL5] Latch-only set: load latches, no program
// [RL6] EEPROM ignores latch-only, always writes
// [RL7] Erase select erases, hardware clears after
// [RL8] EEPROM ignores erase select, erase+write
// [RL9] Error flag set on write-start attempt
// [RL10] Program enable clear blocks all programming
// [RL11] Write start self-timed, hardware clears
// [RL12] Writing zero to write start ignored
// [RL13] Read start one-cycle, set-only, self-clears
// [RL14] Software writes 55h then AAh first
// [RL15] Unlock port write-only, stores nothing
// [RL16] Data pair, high top bits read zero
// [RL17] Bad config read clears data pair
// [RL18] User IDs writable, device ID read-only
// [RL19] Stall processor during Flash write/erase
// [RL20] No unlock or enable means no start
// [RL21] Completion event flag with enable
`timescale 1ns/1ps
`default_nettype none
`include "nvm_params.svh"

module nvm_control #(
   parameter int TIMER_WIDTH = 16,
   parameter int WRITE_CYCLES = `WRITE_TIME_US * `CLOCK_MHZ,
   parameter int ERASE_CYCLES = `ERASE_TIME_US * `CLOCK_MHZ
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic [14:0]      memory_address,
   output logic             flash_space_select,
   output logic             config_space_select,
   output logic [13:0]      mem_wdata,
   input  wire logic [13:0] mem_rdata,
   output logic             mem_read,
   output logic             mem_start,
   output nvm_pkg::op_kind_t mem_op,
   output logic             cpu_stall,
   output logic             nvm_event
);
   import nvm_pkg::*;

   // Register state
   logic [7:0]  addr_low;
   logic [6:0]  addr_high;
   logic        latch_only_load;
   logic        erase_select;
   logic        sequence_error_flag;
   logic        program_enable;
   logic        write_start;
   logic        read_start;
   logic [13:0] memory_data;
   logic        done_flag;
   logic        done_ie;

   logic [7:0]  next_addr_low;
   logic [6:0]  next_addr_high;
   logic        next_flash;
   logic        next_config;
   logic        next_latch;
   logic        next_erase;
   logic        next_error;
   logic        next_enable;
   logic        next_write;
   logic        next_read;
   logic [13:0] next_data;
   logic        next_done_flag;
   logic        next_done_ie;
   logic        next_start;
   op_kind_t    next_op;

   // Bus decode
   logic        access;
   logic        wr;
   logic        mapped;
   logic        wr_ctl;
   logic        wr_unlock;
   logic        armed;
   logic        timer_busy;
   logic        timer_done;
   logic        launch;
   logic        eeprom_sel;
   logic        cfg_ok_read;
   logic        cfg_ok_write;
   logic        blocked;
   logic        setup_rd;
   logic        eff_enable;
   logic        eff_flash;
   logic        eff_config;
   logic        eff_latch;
   logic        eff_erase;
   logic        eff_eeprom;
   logic [31:0] next_prdata;
   logic [TIMER_WIDTH-1:0] op_len;

   assign access    = psel && penable;
   assign wr        = access && pwrite;
   assign wr_ctl    = wr && paddr == `CONTROL_ONE_OFS;
   assign wr_unlock = wr && paddr == `UNLOCK_OFS;
   assign setup_rd  = psel && !penable && !pwrite;
   assign mapped    = paddr == `ADDR_LOW_OFS || paddr == `ADDR_HIGH_OFS ||
                      paddr == `CONTROL_ONE_OFS || paddr == `UNLOCK_OFS ||
                      paddr == `DATA_LOW_OFS || paddr == `DATA_HIGH_OFS ||
                      paddr == `EVENT_OFS;

   // Zero-wait slave; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign pslverr = access && !mapped;

   assign memory_address = {addr_high, addr_low};
   assign eeprom_sel     = !config_space_select && !flash_space_select;

   // Config space map: user IDs and device ID, plus config words read-only
   assign cfg_ok_read  = addr_high == `CFG_HIGH &&
                         (addr_low <= `CFG_USER_LAST ||
                          (addr_low >= `CFG_DEVID && addr_low <= `CFG_WORD_LAST)); // RL17
   assign cfg_ok_write = addr_high == `CFG_HIGH && addr_low <= `CFG_USER_LAST; // RL18

   // Control bits as they stand after this cycle; a write that sets write
   // start is judged by the bits it carries, not by the ones it replaces
   assign eff_enable = wr_ctl ? pwdata[`CTL_ENABLE_BIT] : program_enable; // RL10
   assign eff_flash  = wr_ctl ? pwdata[`CTL_FLASH_BIT] : flash_space_select;
   assign eff_config = wr_ctl ? pwdata[`CTL_CONFIG_BIT] : config_space_select;
   assign eff_latch  = wr_ctl ? pwdata[`CTL_LATCH_BIT] : latch_only_load;
   assign eff_erase  = wr_ctl ? pwdata[`CTL_ERASE_BIT] : erase_select;
   assign eff_eeprom = !eff_config && !eff_flash;

   // Unlock sequence tracker; writes to registers other than unlock and control break it
   nvm_unlock u_unlock (
      .pclk         (pclk),
      .presetn      (presetn),
      .unlock_write (wr_unlock),
      .unlock_data  (pwdata[7:0]),
      .other_write  (wr && !wr_unlock && !wr_ctl),
      .consume      (wr_ctl && pwdata[`CTL_WRITE_BIT]),
      .armed        (armed)
   );

   assign blocked = !eff_enable || !armed ||
                    (eff_config && !cfg_ok_write); // RL10 RL20 RL18
   assign launch  = wr_ctl && pwdata[`CTL_WRITE_BIT] && !write_start && !blocked;
   assign op_len  = eff_erase && !eff_eeprom ? TIMER_WIDTH'(ERASE_CYCLES)
                                             : TIMER_WIDTH'(WRITE_CYCLES);

   // Self-timed operation length, erase and write alike per kind
   nvm_timer #(
      .WIDTH (TIMER_WIDTH)
   ) u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (launch && next_op != op_latch),
      .length  (op_len),
      .busy    (timer_busy),
      .done    (timer_done)
   );

   // Operation kind for the next write command
   always_comb begin
      if (eff_eeprom) begin
         next_op = op_eeprom; // RL6 RL8
      end else if (eff_erase) begin
         next_op = op_erase; // RL7
      end else if (eff_latch) begin
         next_op = op_latch; // RL5
      end else begin
         next_op = op_write; // RL5
      end
   end

   // Register next-state logic; hardware sets beat software clears
   always_comb begin
      next_addr_low  = addr_low;
      next_addr_high = addr_high;
      next_flash     = flash_space_select;
      next_config    = config_space_select;
      next_latch     = latch_only_load;
      next_erase     = erase_select;
      next_error     = sequence_error_flag;
      next_enable    = program_enable;
      next_write     = write_start;
      next_read      = 1'b0; // RL13
      next_data      = memory_data;
      next_done_flag = done_flag;
      next_done_ie   = done_ie;
      next_start     = launch;
      if (wr) begin
         case (paddr)
            `ADDR_LOW_OFS: begin
               next_addr_low = pwdata[7:0]; // RL1
            end
            `ADDR_HIGH_OFS: begin
               next_addr_high = pwdata[6:0]; // RL2
            end
            `DATA_LOW_OFS: begin
               next_data[7:0] = pwdata[7:0]; // RL16
            end
            `DATA_HIGH_OFS: begin
               next_data[13:8] = pwdata[5:0]; // RL16
            end
            `EVENT_OFS: begin
               next_done_ie = pwdata[`EVT_IE_BIT];
               if (pwdata[`EVT_DONE_BIT]) begin
                  next_done_flag = 1'b0;
               end
            end
            `CONTROL_ONE_OFS: begin
               next_flash  = pwdata[`CTL_FLASH_BIT]; // RL3
               next_config = pwdata[`CTL_CONFIG_BIT]; // RL4
               next_latch  = pwdata[`CTL_LATCH_BIT];
               next_erase  = pwdata[`CTL_ERASE_BIT];
               next_error  = pwdata[`CTL_ERROR_BIT];
               next_enable = pwdata[`CTL_ENABLE_BIT];
               if (pwdata[`CTL_WRITE_BIT]) begin
                  next_error = 1'b1; // RL9
                  if (launch) begin
                     next_write = 1'b1; // RL11 RL12
                  end
               end
               if (pwdata[`CTL_READ_BIT] && !write_start) begin
                  next_read = 1'b1; // RL13
               end
            end
            default: begin
            end
         endcase
      end
      // One-cycle read returns data; bad config address clears the pair
      if (read_start) begin
         next_data = (config_space_select && !cfg_ok_read) ? 14'h0000 : mem_rdata; // RL17
      end
      // Latch-only loads finish at once with no timed cycle
      if (launch && next_op == op_latch) begin
         next_write = 1'b0;
         next_error = 1'b0;
      end
      // Normal completion clears the error flag and write start
      if (timer_done) begin
         next_write     = 1'b0; // RL11
         next_error     = 1'b0; // RL9
         next_done_flag = 1'b1; // RL21
         if (!eeprom_sel) begin
            next_erase = 1'b0; // RL7
         end
      end
   end

   // Register update; error flag has no defined reset, cleared anyway
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_low            <= `ADDR_LOW_RST;
         addr_high           <= `ADDR_HIGH_RST;
         flash_space_select  <= 1'b0;
         config_space_select <= 1'b0;
         latch_only_load     <= 1'b0;
         erase_select        <= 1'b0;
         sequence_error_flag <= 1'b0;
         program_enable      <= 1'b0;
         write_start         <= 1'b0;
         read_start          <= 1'b0;
         memory_data         <= 14'h0000;
         done_flag           <= 1'b0;
         done_ie             <= 1'b0;
         mem_start           <= 1'b0;
         mem_op              <= op_write;
         mem_wdata           <= 14'h0000;
      end else begin
         addr_low            <= next_addr_low;
         addr_high           <= next_addr_high;
         flash_space_select  <= next_flash;
         config_space_select <= next_config;
         latch_only_load     <= next_latch;
         erase_select        <= next_erase;
         sequence_error_flag <= next_error;
         program_enable      <= next_enable;
         write_start         <= next_write;
         read_start          <= next_read;
         memory_data         <= next_data;
         done_flag           <= next_done_flag;
         done_ie             <= next_done_ie;
         mem_start           <= next_start; // RL10
         mem_op              <= next_start ? next_op : mem_op;
         mem_wdata           <= next_start ? memory_data : mem_wdata;
      end
   end

   assign mem_read  = read_start; // RL13
   assign cpu_stall = timer_busy && !eeprom_sel; // RL19
   assign nvm_event = done_flag && done_ie; // RL21

   // Read word picked in the setup phase and held in a flop for the access
   // phase; bits that hardware changes may show the state one cycle earlier
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (setup_rd) begin
         case (paddr)
            `ADDR_LOW_OFS: begin
               next_prdata[7:0] = addr_low;
            end
            `ADDR_HIGH_OFS: begin
               next_prdata[7:0] = {1'b1, addr_high}; // RL2
            end
            `CONTROL_ONE_OFS: begin
               next_prdata[7:0] = {flash_space_select, config_space_select,
                                   latch_only_load, erase_select,
                                   sequence_error_flag, program_enable,
                                   write_start, read_start};
            end
            `UNLOCK_OFS: begin
               next_prdata[7:0] = 8'h00; // RL15
            end
            `DATA_LOW_OFS: begin
               next_prdata[7:0] = memory_data[7:0];
            end
            `DATA_HIGH_OFS: begin
               next_prdata[7:0] = {2'b00, memory_data[13:8]}; // RL16
            end
            `EVENT_OFS: begin
               next_prdata[1:0] = {done_ie, done_flag};
            end
            default: begin
               next_prdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // Read data flop; unlock port reads zero since nothing is stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= next_prdata;
      end
   end
endmodule
`default_nettype wire

//--- rtl/nvm_params.svh
// Register offsets, field positions, reset values and timing counts for the NVM control block
`ifndef NVM_PARAMS_SVH
`define NVM_PARAMS_SVH

// Register byte offsets on APB
`define ADDR_LOW_OFS     12'h000
`define ADDR_HIGH_OFS    12'h004
`define CONTROL_ONE_OFS  12'h008
`define UNLOCK_OFS       12'h00C
`define DATA_LOW_OFS     12'h010
`define DATA_HIGH_OFS    12'h014
`define EVENT_OFS        12'h018

// Control register field positions
`define CTL_FLASH_BIT    7
`define CTL_CONFIG_BIT   6
`define CTL_LATCH_BIT    5
`define CTL_ERASE_BIT    4
`define CTL_ERROR_BIT    3
`define CTL_ENABLE_BIT   2
`define CTL_WRITE_BIT    1
`define CTL_READ_BIT     0

// Event register field positions
`define EVT_DONE_BIT     0
`define EVT_IE_BIT       1

// Reset values and fixed patterns
`define ADDR_LOW_RST     8'h00
`define ADDR_HIGH_RST    7'h00
`define UNLOCK_FIRST     8'h55
`define UNLOCK_SECOND    8'hAA

// Configuration space map, high address byte and low byte limits
`define CFG_HIGH         7'h00
`define CFG_USER_LAST    8'h03
`define CFG_DEVID        8'h06
`define CFG_WORD_LAST    8'h08

// Self-timed operation lengths
`define WRITE_TIME_US    2
`define ERASE_TIME_US    2
`define CLOCK_MHZ        25

`endif

//--- rtl/nvm_pkg.sv
// Types shared by the NVM control block
package nvm_pkg;
   typedef enum logic [1:0] {
      op_write,
      op_erase,
      op_eeprom,
      op_latch
   } op_kind_t;

   typedef enum logic [1:0] {
      seq_idle,
      seq_first,
      seq_armed
   } unlock_state_t;
endpackage

//--- rtl/nvm_unlock.sv
// Unlock pattern detector fed by writes to the unlock port
`timescale 1ns/1ps
`default_nettype none
`include "nvm_params.svh"

module nvm_unlock (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       unlock_write,
   input  wire logic [7:0] unlock_data,
   input  wire logic       other_write,
   input  wire logic       consume,
   output logic            armed
);
   import nvm_pkg::*;

   unlock_state_t state;
   unlock_state_t next_state;

   // Other writes, and control writes that set write start, break the sequence between steps
   always_comb begin
      next_state = state;
      if (consume || other_write) begin
         next_state = seq_idle;
      end else if (unlock_write) begin
         case (state)
            seq_first: begin
               if (unlock_data == `UNLOCK_SECOND) begin
                  next_state = seq_armed;
               end else if (unlock_data != `UNLOCK_FIRST) begin
                  next_state = seq_idle;
               end
            end
            default: begin
               next_state = (unlock_data == `UNLOCK_FIRST) ? seq_first : seq_idle;
            end
         endcase
      end
   end

   // Only the pattern state is kept; written bytes are never stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= seq_idle;
      end else begin
         state <= next_state;
      end
   end

   assign armed = (state == seq_armed);
endmodule
`default_nettype wire

//--- rtl/nvm_timer.sv
// Down-counter timing one self-timed operation
`timescale 1ns/1ps
`default_nettype none

module nvm_timer #(
   parameter int WIDTH = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             start,
   input  wire logic [WIDTH-1:0] length,
   output logic                  busy,
   output logic                  done
);
   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;
   logic             next_busy;
   logic             next_done;

   // Load on start, pulse done on the last count
   always_comb begin
      next_count = count;
      next_busy  = busy;
      next_done  = 1'b0;
      if (start && !busy) begin
         next_count = length;
         next_busy  = 1'b1;
      end else if (busy) begin
         if (count <= WIDTH'(1)) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end else begin
            next_count = count - WIDTH'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else begin
         count <= next_count;
         busy  <= next_busy;
         done  <= next_done;
      end
   end
endmodule
`default_nettype wire

//--- testbench/nvm_control_checker.sv
// Port-level assertions for the NVM control block
`timescale 1ns/1ps
`default_nettype none
`include "nvm_params.svh"
module nvm_control_checker (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [11:0]       paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              flash_space_select,
   input wire logic              config_space_select,
   input wire logic              mem_read,
   input wire logic              mem_start,
   input wire nvm_pkg::op_kind_t mem_op,
   input wire logic              cpu_stall
);
   import nvm_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Decoded access phases
   wire logic acc = psel & penable;
   wire logic ctl_wr = acc & pwrite & (paddr == `CONTROL_ONE_OFS);
   wire logic rd_acc = acc & !pwrite;
   sequence s_go;
      ctl_wr && pwdata[`CTL_WRITE_BIT];
   endsequence
   sequence s_busy;
      cpu_stall[*2] ##[1:20] !cpu_stall;
   endsequence
   AST_START_CAUSE: assert property ($rose(mem_start) |-> $past(ctl_wr && pwdata[1]))
      else $error("launch without a write-start request");
   AST_READ_CAUSE: assert property (ctl_wr && pwdata[0] |-> ##1 mem_read)
      else $error("read strobe missing");
   AST_READ_ONE: assert property (mem_read |=> !mem_read)
      else $error("read strobe longer than one cycle");
   AST_EE_OP: assert property (mem_start && !flash_space_select && !config_space_select
      |-> mem_op == op_eeprom)
      else $error("data memory launch not erase plus write");
   AST_STALL_EE: assert property (cpu_stall |-> flash_space_select || config_space_select)
      else $error("stall during data memory operation");
   AST_STALL_LEN: assert property ($rose(cpu_stall) |-> s_busy)
      else $error("stall length out of range");
   AST_PREADY: assert property (pready)
      else $error("wait state inserted");
   AST_SLVERR: assert property (acc && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h018))
      else $error("slave error decode wrong");
   AST_HIGH_ADDR: assert property (rd_acc && paddr == `ADDR_HIGH_OFS |-> prdata[31:7] == 25'h1)
      else $error("address high top bit not one");
   AST_DATA_HIGH: assert property (rd_acc && paddr == `DATA_HIGH_OFS |-> prdata[31:6] == 26'h0)
      else $error("data high top bits not zero");
   AST_UNLOCK_RD: assert property (rd_acc && paddr == `UNLOCK_OFS |-> prdata == 32'h0)
      else $error("unlock port returned data");
   cover property (s_go);
endmodule
bind nvm_control nvm_control_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .flash_space_select, .config_space_select, .mem_read,
   .mem_start, .mem_op, .cpu_stall);
`default_nettype wire

//--- testbench/nvm_array_model.sv
// Behavioural Flash, data EEPROM and config arrays behind the control block
`timescale 1ns/1ps
`default_nettype none
module nvm_array_model (
   input wire logic              pclk,
   input wire logic [14:0]       memory_address,
   input wire logic              flash_space_select,
   input wire logic              config_space_select,
   input wire logic [13:0]       mem_wdata,
   input wire logic              mem_read,
   input wire logic              mem_start,
   input wire nvm_pkg::op_kind_t mem_op,
   output logic [13:0]           mem_rdata
);
   import nvm_pkg::*;
   logic [13:0] cells [logic [16:0]];
   logic [13:0] idle_pat = 14'h2AAA;
   logic [16:0] key;
   // Space bits keep the three arrays apart
   assign key = {config_space_select, flash_space_select, memory_address};
   // Stale data churns each cycle between 2AAAh and 1555h, the unwritten-cell value, so a late sample can match by luck
   always_comb begin
      if (!mem_read) mem_rdata = idle_pat;
      else if (cells.exists(key)) mem_rdata = cells[key];
      else mem_rdata = 14'h1555;
   end
   // Erase fills ones; writes store the launched data pair, latch loads keep the array
   always @(posedge pclk) begin
      idle_pat <= ~idle_pat;
      if (mem_start && mem_op == op_erase) cells[key] = 14'h3FFF;
      if (mem_start && mem_op inside {op_write, op_eeprom}) cells[key] = mem_wdata;
   end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the NVM control block
`timescale 1ns/1ps
`default_nettype none
`include "nvm_params.svh"
module testbench;
   import nvm_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic        pready, pslverr, flash_space_select, config_space_select;
   logic        mem_read, mem_start, cpu_stall, nvm_event;
   logic [14:0] memory_address;
   logic [13:0] mem_wdata, mem_rdata;
   op_kind_t    mem_op, last_op;
   int          n_mismatch = 0, cmp_count = 0, starts = 0, stalls = 0, cyc = 0;
   always #20 pclk = ~pclk;
   // Timer shortened so a zero write still lands mid-operation
   nvm_control #(.WRITE_CYCLES(12), .ERASE_CYCLES(12)) dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .memory_address,
      .flash_space_select, .config_space_select, .mem_wdata, .mem_rdata, .mem_read,
      .mem_start, .mem_op, .cpu_stall, .nvm_event);
   nvm_array_model mdl (.pclk, .memory_address, .flash_space_select, .config_space_select,
      .mem_wdata, .mem_read, .mem_start, .mem_op, .mem_rdata);
   // Launch and stall counters, plus the hang limit
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (mem_start) starts <= starts + 1;
      if (mem_start) last_op <= mem_op;
      if (cpu_stall) stalls <= stalls + 1;
      if (cyc == 8000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic give_verdict;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk); // Let flops settle before callers look at outputs
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic unlock;
      wr(`UNLOCK_OFS, 32'h55);
      wr(`UNLOCK_OFS, 32'hAA);
   endtask
   task automatic wait_idle;
      do apb(1'b0, `CONTROL_ONE_OFS, 32'h0); while (rd[1] === 1'b1);
   endtask
   task automatic t_regs;
      rdc(`ADDR_LOW_OFS, 32'h0);
      rdc(`ADDR_HIGH_OFS, 32'h80);
      rdc(`UNLOCK_OFS, 32'h0);
      rdc(12'h01C, 32'h0);
      wr(`ADDR_HIGH_OFS, 32'hFF);
      rdc(`ADDR_HIGH_OFS, 32'hFF);
      wr(`ADDR_LOW_OFS, 32'h34);
      wr(`ADDR_HIGH_OFS, 32'h12);
      chk({17'h0, memory_address}, 32'h1234);
      wr(`DATA_LOW_OFS, 32'hCD);
      wr(`DATA_HIGH_OFS, 32'hFF);
      rdc(`DATA_HIGH_OFS, 32'h3F);
   endtask
   task automatic t_eeprom;
      int s0;
      s0 = starts;
      wr(`EVENT_OFS, 32'h2);
      wr(`CONTROL_ONE_OFS, 32'h34);
      unlock();
      wr(`CONTROL_ONE_OFS, 32'h36);
      rdc(`CONTROL_ONE_OFS, 32'h3E);
      chk({30'h0, last_op}, {30'h0, op_eeprom});
      wait_idle();
      chk(rd, 32'h34);
      chk(starts - s0, 1);
      chk(stalls, 0);
      chk(nvm_event, 1);
      wr(`EVENT_OFS, 32'h3);
      rdc(`EVENT_OFS, 32'h2);
   endtask
   task automatic t_blocked;
      int s0;
      s0 = starts;
      wr(`CONTROL_ONE_OFS, 32'h06);
      rdc(`CONTROL_ONE_OFS, 32'h0C);
      unlock();
      wr(`CONTROL_ONE_OFS, 32'h02);
      rdc(`CONTROL_ONE_OFS, 32'h08);
      chk(starts - s0, 0);
   endtask
   task automatic t_flash;
      logic [7:0] ctl [3] = '{8'h96, 8'h86, 8'hA6};
      op_kind_t ops [3] = '{op_erase, op_write, op_latch};
      int st0;
      for (int i = 0; i < 3; i++) begin
         st0 = stalls;
         wr(`CONTROL_ONE_OFS, {24'h0, ctl[i] & 8'hFD});
         unlock();
         wr(`CONTROL_ONE_OFS, {24'h0, ctl[i]});
         wr(`CONTROL_ONE_OFS, {24'h0, ctl[i] & 8'hFD});
         apb(1'b0, `CONTROL_ONE_OFS, 32'h0);
         chk(rd[1], i < 2);
         wait_idle();
         chk(rd, {24'h0, ctl[i] & 8'hE5});
         chk({30'h0, last_op}, {30'h0, ops[i]});
         chk(stalls != st0, i < 2);
      end
   endtask
   task automatic t_config;
      int s0;
      wr(`ADDR_HIGH_OFS, 32'h0);
      wr(`ADDR_LOW_OFS, 32'h2);
      wr(`CONTROL_ONE_OFS, 32'h44);
      unlock();
      wr(`CONTROL_ONE_OFS, 32'h46);
      wait_idle();
      chk({30'h0, last_op}, {30'h0, op_write});
      wr(`ADDR_LOW_OFS, 32'h6);
      unlock();
      s0 = starts;
      wr(`CONTROL_ONE_OFS, 32'h46);
      rdc(`CONTROL_ONE_OFS, 32'h4C);
      chk(starts - s0, 0);
   endtask
   // Read one word and check strobe self-clear and the data pair
   task automatic rd_word(input logic [14:0] a, input logic [7:0] c, input logic [13:0] exp);
      wr(`ADDR_HIGH_OFS, {25'h0, a[14:8]});
      wr(`ADDR_LOW_OFS, {24'h0, a[7:0]});
      wr(`CONTROL_ONE_OFS, {24'h0, c});
      rdc(`CONTROL_ONE_OFS, {24'h0, c & 8'hFE});
      rdc(`DATA_LOW_OFS, {24'h0, exp[7:0]});
      rdc(`DATA_HIGH_OFS, {26'h0, exp[13:8]});
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_eeprom();
      t_blocked();
      wr(`ADDR_LOW_OFS, 32'h34);
      wr(`ADDR_HIGH_OFS, 32'h12);
      t_flash();
      t_config();
      rd_word(15'h1234, 8'h01, 14'h3FCD);
      rd_word(15'h1234, 8'h81, 14'h3FCD);
      rd_word(15'h0002, 8'h41, 14'h3FCD);
      rd_word(15'h0002, 8'h81, 14'h1555);
      rd_word(15'h0004, 8'h41, 14'h0000);
      give_verdict();
   end
endmodule
`default_nettype wire
